// *** core/asi_status_irq.sv ***
// serial status flags, clear sequences, interrupt request and low-power gating
//
// What this block does
// [R1] in wait mode the block runs on; an enabled interrupt wakes the device
// [R2] in halt mode registers freeze, transfers pause, no serial wakeup
// [R3] every serial interrupt source shares one request line
// [R4] a source requests only if enabled and the cpu mask is clear
// [R5] status resets to C0h, all bits read-only
// [R6] tx empty sets when the holding buffer moves to the shifter
// [R7] tx empty and tx done clear by status read then data write
// [R8] the holding buffer never moves while tx empty is set
// [R9] tx empty with its enable requests an interrupt
// [R10] tx done sets after a data frame, not after preamble or break
// [R11] rx ready sets when a word reaches the software data register
// [R12] rx ready, idle, overrun, noise, framing clear by status then data read
// [R13] rx ready or overrun request an interrupt when rx enable is set
// [R14] idle sets on idle line, may request, rearms only after rx ready
// [R15] overrun sets when a new word arrives while rx ready is set
// [R16] on overrun the holding buffer keeps its word
// [R17] noise flag sets on noisy frame and never requests alone
// [R18] framing flag sets on desync, heavy noise or break, no own request
// [R19] framing fault with overrun keeps the old word, only overrun sets
// [R20] parity flag sets on mismatch and may request
// [R21] parity flag clears by status read then any data access
// [R22] while muted no rx flag sets and rx interrupts are off
// [R23] status read arms a clear, next data access ends it; new events win
`timescale 1ns/1ns
module asi_status_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asi_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_shift_free,
  input wire logic tx_frame_done,
  input wire logic tx_frame_data,
  input wire logic rx_word_valid,
  input wire logic [asi_pkg::DATA_W-1:0] rx_word,
  input wire logic rx_noise,
  input wire logic rx_framing,
  input wire logic rx_parity,
  input wire logic idle_detect,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic cpu_irq_mask,
  output logic irq_req,
  output logic wait_wake,
  output logic tx_load,
  output logic [asi_pkg::DATA_W-1:0] tx_data,
  output logic serial_pause
);
  typedef struct packed {
    logic [7:0] stat;
    logic [7:0] ctrl;
    logic [asi_pkg::DATA_W-1:0] txb;
    logic [asi_pkg::DATA_W-1:0] rxb;
    logic idle_arm;
    logic [31:0] rd;
  } asi_regs_t;

  localparam asi_regs_t REGS_RST = '{
    stat: asi_pkg::STATUS_RST,
    ctrl: asi_pkg::CTRL_RST,
    txb: asi_pkg::BUF_RST,
    rxb: asi_pkg::BUF_RST,
    idle_arm: 1'b1,
    rd: 32'h0000_0000
  };

  asi_regs_t r_reg;
  asi_regs_t r_next;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic setup;
  logic acc;
  logic hit;
  logic status_rd;
  logic data_rd;
  logic data_wr;
  logic ctrl_wr;
  logic clr_tx;
  logic clr_rx;
  logic clr_par;

  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign hit = (paddr == asi_pkg::OFF_STATUS) | (paddr == asi_pkg::OFF_DATA)
             | (paddr == asi_pkg::OFF_CTRL);
  // zero-wait slave; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = r_reg.rd;
  // status is read-only: a write to it is accepted and dropped
  assign status_rd = acc & ~pwrite & (paddr == asi_pkg::OFF_STATUS); // R5
  assign data_rd = acc & ~pwrite & (paddr == asi_pkg::OFF_DATA);
  assign data_wr = acc & pwrite & (paddr == asi_pkg::OFF_DATA);
  assign ctrl_wr = acc & pwrite & (paddr == asi_pkg::OFF_CTRL);

  asi_clr_seq u_clr (
    .pclk(pclk),
    .presetn(presetn),
    .halt_mode(halt_mode),
    .status_rd(status_rd),
    .data_rd(data_rd),
    .data_wr(data_wr),
    .clr_tx(clr_tx),
    .clr_rx(clr_rx),
    .clr_par(clr_par)
  );

  // ****************************************************************
  // event qualification
  // ****************************************************************
  logic mute;
  logic rx_take;
  logic rx_ovr;
  logic idle_set;
  logic txd_set;

  assign mute = r_reg.ctrl[asi_pkg::C_MUTE];
  // the engine is paused in halt, so events are not expected then; drop them anyway
  assign serial_pause = halt_mode; // R2
  assign tx_load = ~r_reg.stat[asi_pkg::B_TXE] & tx_shift_free & ~halt_mode; // R8
  assign tx_data = r_reg.txb;
  assign txd_set = tx_frame_done & tx_frame_data & ~halt_mode; // R10
  assign rx_take = rx_word_valid & ~mute & ~halt_mode; // R22
  // a word landing on the edge that empties the buffer is taken, not an overrun
  assign rx_ovr = rx_take & r_reg.stat[asi_pkg::B_RXR] & ~clr_rx; // R15 R23
  assign idle_set = idle_detect & r_reg.idle_arm & ~mute & ~halt_mode; // R14 R22

  // ****************************************************************
  // state update
  // ****************************************************************
  always_comb
  begin
    r_next = r_reg;
    if (setup)
    begin
      case (paddr)
        asi_pkg::OFF_STATUS: r_next.rd = {24'h000000, r_reg.stat};
        asi_pkg::OFF_DATA: r_next.rd = {24'h000000, r_reg.rxb};
        asi_pkg::OFF_CTRL: r_next.rd = {24'h000000, r_reg.ctrl};
        default: r_next.rd = 32'h0000_0000;
      endcase
    end
    // halt freezes every serial register; only bus read data moves
    if (!halt_mode) // R2
    begin
      if (ctrl_wr)
        r_next.ctrl = pwdata[7:0] & asi_pkg::CTRL_MASK;
      if (data_wr)
        r_next.txb = pwdata[asi_pkg::DATA_W-1:0];
      // clears first, so an event in the same cycle sets again
      if (clr_tx) // R7
      begin
        r_next.stat[asi_pkg::B_TXE] = 1'b0;
        r_next.stat[asi_pkg::B_TXD] = 1'b0;
      end
      if (clr_rx) // R12
      begin
        r_next.stat[asi_pkg::B_RXR] = 1'b0;
        r_next.stat[asi_pkg::B_IDLE] = 1'b0;
        r_next.stat[asi_pkg::B_OVR] = 1'b0;
        r_next.stat[asi_pkg::B_NOISE] = 1'b0;
        r_next.stat[asi_pkg::B_FRM] = 1'b0;
      end
      if (clr_par)
        r_next.stat[asi_pkg::B_PAR] = 1'b0; // R21
      if (tx_load)
        r_next.stat[asi_pkg::B_TXE] = 1'b1; // R6 R23
      if (txd_set)
        r_next.stat[asi_pkg::B_TXD] = 1'b1; // R10 R23
      if (rx_ovr)
        r_next.stat[asi_pkg::B_OVR] = 1'b1; // R15 R16 R19 R23
      else if (rx_take)
      begin
        r_next.rxb = rx_word; // R11
        r_next.stat[asi_pkg::B_RXR] = 1'b1; // R11 R23
        r_next.idle_arm = 1'b1; // R14
        if (rx_noise)
          r_next.stat[asi_pkg::B_NOISE] = 1'b1; // R17
        if (rx_framing)
          r_next.stat[asi_pkg::B_FRM] = 1'b1; // R18
        if (rx_parity)
          r_next.stat[asi_pkg::B_PAR] = 1'b1; // R20
      end
      if (idle_set)
      begin
        r_next.stat[asi_pkg::B_IDLE] = 1'b1; // R14 R23
        r_next.idle_arm = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= REGS_RST; // R5
    else
      r_reg <= r_next;
  end

  // ****************************************************************
  // interrupt and wakeup
  // ****************************************************************
  asi_irq_merge u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .stat(r_reg.stat),
    .ctrl(r_reg.ctrl),
    .cpu_irq_mask(cpu_irq_mask),
    .irq_req(irq_req)
  );

  // wait leaves the block running; halt never wakes on a serial event
  assign wait_wake = irq_req & wait_mode & ~halt_mode; // R1 R2

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_stat_rd;
    status_rd && !halt_mode;
  endsequence

  sequence s_data_wr_quiet;
    data_wr && !halt_mode && !tx_frame_done && !tx_load;
  endsequence

  sequence s_data_rd_quiet;
    data_rd && !halt_mode && !rx_word_valid && !idle_detect;
  endsequence

  property p_tx_clear;
    @(posedge pclk) disable iff (!presetn)
    // the data access follows at once or after one idle bus cycle
    s_stat_rd ##[2:3] s_data_wr_quiet
    |=> !r_reg.stat[asi_pkg::B_TXE] && !r_reg.stat[asi_pkg::B_TXD];
  endproperty

  property p_rx_clear;
    @(posedge pclk) disable iff (!presetn)
    s_stat_rd ##[2:3] s_data_rd_quiet |=> (r_reg.stat & 8'h3F) == 8'h00;
  endproperty

  a_tx_clear_seq: assert property (p_tx_clear)
    else $error("tx flags not cleared by status then data write"); // R7
  a_rx_clear_seq: assert property (p_rx_clear)
    else $error("rx flags not cleared by status then data read"); // R12 R21
  a_load_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    r_reg.stat[asi_pkg::B_TXE] |-> !tx_load)
    else $error("holding buffer moved while tx empty set"); // R8
  a_load_sets_txe: assert property (@(posedge pclk) disable iff (!presetn)
    tx_load |=> r_reg.stat[asi_pkg::B_TXE] && tx_data == $past(r_reg.txb))
    else $error("tx empty not set after load"); // R6
  a_txd_data_only: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_frame_done && !tx_frame_data && !r_reg.stat[asi_pkg::B_TXD])
    |=> !r_reg.stat[asi_pkg::B_TXD])
    else $error("tx done set after preamble or break"); // R10
  a_txd_sets: assert property (@(posedge pclk) disable iff (!presetn)
    txd_set |=> r_reg.stat[asi_pkg::B_TXD])
    else $error("tx done missed"); // R10 R23
  a_rx_ready_set: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_take && !r_reg.stat[asi_pkg::B_RXR])
    |=> r_reg.stat[asi_pkg::B_RXR] && r_reg.rxb == $past(rx_word))
    else $error("rx word not delivered"); // R11
  a_ovr_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    rx_ovr |=> r_reg.stat[asi_pkg::B_OVR] && $stable(r_reg.rxb)
    && ($past(r_reg.stat[asi_pkg::B_FRM]) || !r_reg.stat[asi_pkg::B_FRM]))
    else $error("overrun lost or buffer overwritten"); // R15 R16 R19
  a_halt_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    halt_mode |=> $stable(r_reg.stat) && $stable(r_reg.ctrl) && $stable(r_reg.rxb))
    else $error("register moved during halt"); // R2
  a_halt_no_wake: assert property (@(posedge pclk) disable iff (!presetn)
    halt_mode |-> !wait_wake && !tx_load)
    else $error("serial activity in halt"); // R2
  a_wait_wakes: assert property (@(posedge pclk) disable iff (!presetn)
    (wait_mode && !halt_mode && irq_req) |-> wait_wake)
    else $error("enabled interrupt did not wake from wait"); // R1
  a_mute_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    mute |=> !$rose(r_reg.stat[asi_pkg::B_RXR]) && !$rose(r_reg.stat[asi_pkg::B_IDLE])
    && !$rose(r_reg.stat[asi_pkg::B_PAR]))
    else $error("rx flag set while muted"); // R22
  a_idle_once: assert property (@(posedge pclk) disable iff (!presetn)
    idle_set ##1 (!rx_take [*2]) |-> !idle_set)
    else $error("idle rearmed without rx ready"); // R14
  a_rx_req: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.stat[asi_pkg::B_OVR] && r_reg.ctrl[asi_pkg::C_RX_IE] && !mute && !cpu_irq_mask)
    |-> irq_req)
    else $error("overrun did not request"); // R13
endmodule

// *** core/asi_pkg.sv ***
// constants shared by the serial status and interrupt block
package asi_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] STATUS_RST = 8'hC0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'hF3;
  // status bit positions
  localparam int B_TXE = 7;
  localparam int B_TXD = 6;
  localparam int B_RXR = 5;
  localparam int B_IDLE = 4;
  localparam int B_OVR = 3;
  localparam int B_NOISE = 2;
  localparam int B_FRM = 1;
  localparam int B_PAR = 0;
  // control bit positions
  localparam int C_TXE_IE = 7;
  localparam int C_TXD_IE = 6;
  localparam int C_RX_IE = 5;
  localparam int C_IDLE_IE = 4;
  localparam int C_MUTE = 1;
  localparam int C_PAR_IE = 0;
endpackage

// *** core/asi_clr_seq.sv ***
// two-step flag clear sequencer: status read arms, data access completes
`timescale 1ns/1ns
module asi_clr_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic halt_mode,
  input wire logic status_rd,
  input wire logic data_rd,
  input wire logic data_wr,
  output logic clr_tx,
  output logic clr_rx,
  output logic clr_par
);
  typedef struct packed {
    logic armed;
  } asi_seq_t;

  asi_seq_t s_reg;
  asi_seq_t s_next;

  // clears only fire from an armed state, and never while frozen
  assign clr_tx = s_reg.armed & data_wr & ~halt_mode; // R7 R23
  assign clr_rx = s_reg.armed & data_rd & ~halt_mode; // R12 R23
  assign clr_par = s_reg.armed & (data_rd | data_wr) & ~halt_mode; // R21

  always_comb
  begin
    s_next = s_reg;
    if (!halt_mode)
    begin
      if (status_rd)
        s_next.armed = 1'b1; // R23
      else if (data_rd | data_wr)
        s_next.armed = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  a_clr_needs_arm: assert property (@(posedge pclk) disable iff (!presetn)
    (data_wr && !halt_mode) |-> (clr_tx == $past(s_reg.armed || status_rd)) || status_rd)
    else $error("tx clear without prior status read"); // R7
endmodule

// *** core/asi_irq_merge.sv ***
// merges enabled serial events onto the single interrupt request line
`timescale 1ns/1ns
module asi_irq_merge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] stat,
  input wire logic [7:0] ctrl,
  input wire logic cpu_irq_mask,
  output logic irq_req
);
  logic mute;
  logic src;

  assign mute = ctrl[asi_pkg::C_MUTE];
  // noise and framing flags ride along with rx ready, so they have no source
  assign src = (ctrl[asi_pkg::C_TXE_IE] & stat[asi_pkg::B_TXE]) // R9
             | (ctrl[asi_pkg::C_TXD_IE] & stat[asi_pkg::B_TXD]) // R10
             | (~mute & ctrl[asi_pkg::C_RX_IE]
                & (stat[asi_pkg::B_RXR] | stat[asi_pkg::B_OVR])) // R13 R22
             | (~mute & ctrl[asi_pkg::C_IDLE_IE] & stat[asi_pkg::B_IDLE]) // R14 R22
             | (~mute & ctrl[asi_pkg::C_PAR_IE] & stat[asi_pkg::B_PAR]); // R20 R22
  assign irq_req = src & ~cpu_irq_mask; // R3 R4

  a_noise_silent: assert property (@(posedge pclk) disable iff (!presetn)
    ((stat & 8'hF9) == 8'h00) |-> !irq_req)
    else $error("noise or framing flag raised the request"); // R17 R18
  a_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_irq_mask |-> !irq_req)
    else $error("request while cpu mask set"); // R4
  a_tx_empty_req: assert property (@(posedge pclk) disable iff (!presetn)
    (stat[asi_pkg::B_TXE] && ctrl[asi_pkg::C_TXE_IE] && !cpu_irq_mask) |-> irq_req)
    else $error("tx empty did not request"); // R9 R3
endmodule

// *** verification/asi_far_end.sv ***
// model of the serial engine that feeds events into the status block
`timescale 1ns/1ns
module asi_far_end (
  input wire logic pclk,
  output logic tx_shift_free,
  output logic tx_frame_done,
  output logic tx_frame_data,
  output logic rx_word_valid,
  output logic [7:0] rx_word,
  output logic rx_noise,
  output logic rx_framing,
  output logic rx_parity,
  output logic idle_detect
);
  // ********
  // event strobes
  // ********
  // busy holds the shifter off so the holding buffer can be watched while it waits
  logic busy = 1'b1;
  assign tx_shift_free = ~busy;
  initial
  begin
    tx_frame_done = 1'b0;
    tx_frame_data = 1'b0;
    rx_word_valid = 1'b0;
    rx_word = 8'hFF;
    {rx_noise, rx_framing, rx_parity} = 3'h7;
    idle_detect = 1'b0;
  end
  task automatic rx(input logic [7:0] w, input logic [2:0] e);
    @(posedge pclk);
    rx_word_valid <= 1'b1;
    rx_word <= w;
    {rx_noise, rx_framing, rx_parity} <= e;
    @(posedge pclk);
    rx_word_valid <= 1'b0;
    // word and qualifiers mean nothing outside the strobe
    rx_word <= ~w;
    {rx_noise, rx_framing, rx_parity} <= ~e;
  endtask
  task automatic frame(input logic d);
    @(posedge pclk);
    tx_frame_done <= 1'b1;
    tx_frame_data <= d;
    @(posedge pclk);
    tx_frame_done <= 1'b0;
    tx_frame_data <= ~d;
  endtask
  task automatic idle();
    @(posedge pclk);
    idle_detect <= 1'b1;
    @(posedge pclk);
    idle_detect <= 1'b0;
  endtask
endmodule

// *** verification/asi_status_irq_bench.sv ***
// self-checking bench for the serial status and interrupt block
`timescale 1ns/1ns
module asi_status_irq_bench;
  // ********
  // signals and instances
  // ********
  localparam logic [7:0] ST = asi_pkg::OFF_STATUS;
  localparam logic [7:0] DT = asi_pkg::OFF_DATA;
  localparam logic [7:0] CT = asi_pkg::OFF_CTRL;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, err, irq_req, wait_wake, tx_load, serial_pause;
  logic halt_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic cpu_irq_mask = 1'b0;
  logic [7:0] tx_data, rx_word;
  logic tx_shift_free, tx_frame_done, tx_frame_data, rx_word_valid;
  logic rx_noise, rx_framing, rx_parity, idle_detect;
  int fails = 0;
  int n_compared = 0;
  int nload = 0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (tx_load === 1'b1) nload++;
  asi_status_irq uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_shift_free(tx_shift_free), .tx_frame_done(tx_frame_done),
    .tx_frame_data(tx_frame_data), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .rx_noise(rx_noise), .rx_framing(rx_framing), .rx_parity(rx_parity),
    .idle_detect(idle_detect), .halt_mode(halt_mode), .wait_mode(wait_mode),
    .cpu_irq_mask(cpu_irq_mask), .irq_req(irq_req), .wait_wake(wait_wake),
    .tx_load(tx_load), .tx_data(tx_data), .serial_pause(serial_pause));
  asi_far_end far (.pclk(pclk), .tx_shift_free(tx_shift_free), .tx_frame_done(tx_frame_done),
    .tx_frame_data(tx_frame_data), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
    .rx_noise(rx_noise), .rx_framing(rx_framing), .rx_parity(rx_parity),
    .idle_detect(idle_detect));
  // ********
  // tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", {24'h0, e}, q & {24'h0, m});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic irq(input logic e);
    @(negedge pclk);
    chk("irq_req", {31'h0, e}, {31'h0, irq_req});
  endtask
  task automatic print_verdict();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge pclk);
    fails++;
    print_verdict();
  end
  // ********
  // tests
  // ********
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ST, 8'hFF, asi_pkg::STATUS_RST);
    rd(CT, 8'hFF, 8'h00);
    wr(ST, 8'h00);
    rd(ST, 8'hFF, 8'hC0);
    chk("upper", 32'h0, q & 32'hFFFFFF00);
    apb(1'b0, 8'h0C, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test reset done");
    wr(CT, 8'h80);
    irq(1'b1);
    @(posedge pclk);
    cpu_irq_mask <= 1'b1;
    irq(1'b0);
    @(posedge pclk);
    cpu_irq_mask <= 1'b0;
    wait_mode <= 1'b1;
    @(negedge pclk);
    chk("wake", 32'h1, {31'h0, wait_wake});
    @(posedge pclk);
    halt_mode <= 1'b1;
    @(negedge pclk);
    chk("wake", 32'h0, {31'h0, wait_wake});
    chk("pause", 32'h1, {31'h0, serial_pause});
    wr(CT, 8'h00);
    rd(CT, 8'hFF, 8'h80);
    @(posedge pclk);
    halt_mode <= 1'b0;
    wait_mode <= 1'b0;
    apb(1'b0, DT, 32'h0);
    wr(DT, 8'h5A);
    rd(ST, 8'hFF, 8'hC0);
    wr(DT, 8'hA5);
    rd(ST, 8'hFF, 8'h00);
    chk("tx_data", 32'hA5, {24'h0, tx_data});
    irq(1'b0);
    chk("loads", 32'h0, nload);
    @(posedge pclk);
    far.busy <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("loads", 32'h1, nload);
    rd(ST, 8'h80, 8'h80);
    $display("test transmit done");
    far.frame(1'b0);
    rd(ST, 8'h40, 8'h00);
    far.frame(1'b1);
    rd(ST, 8'h40, 8'h40);
    wr(CT, 8'h40);
    irq(1'b1);
    wr(CT, 8'h20);
    far.rx(8'h3C, 3'b100);
    rd(ST, 8'h3F, 8'h24);
    irq(1'b1);
    far.rx(8'h99, 3'b010);
    rd(ST, 8'h3F, 8'h2C);
    rd(DT, 8'hFF, 8'h3C);
    rd(ST, 8'h3F, 8'h00);
    irq(1'b0);
    wr(CT, 8'h01);
    far.rx(8'h11, 3'b001);
    rd(ST, 8'h3F, 8'h21);
    irq(1'b1);
    wr(DT, 8'h00);
    rd(DT, 8'hFF, 8'h11);
    rd(ST, 8'h3F, 8'h20);
    apb(1'b0, DT, 32'h0);
    $display("test receive done");
    wr(CT, 8'h10);
    far.idle();
    rd(ST, 8'h3F, 8'h10);
    irq(1'b1);
    apb(1'b0, DT, 32'h0);
    rd(ST, 8'h3F, 8'h00);
    far.idle();
    rd(ST, 8'h3F, 8'h00);
    far.rx(8'h77, 3'b000);
    far.idle();
    rd(ST, 8'h3F, 8'h30);
    // a new word arrives on the very edge of the clearing data read
    fork
      apb(1'b0, DT, 32'h0);
      begin
        @(posedge pclk);
        far.rx(8'h66, 3'b000);
      end
    join
    rd(ST, 8'h3F, 8'h20);
    rd(DT, 8'hFF, 8'h66);
    wr(CT, 8'h02);
    far.rx(8'h42, 3'b111);
    far.idle();
    rd(ST, 8'h3F, 8'h00);
    irq(1'b0);
    $display("test idle and mute done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ST, 8'hFF, asi_pkg::STATUS_RST);
    rd(CT, 8'hFF, asi_pkg::CTRL_RST);
    chk("tx_data", {24'h0, asi_pkg::BUF_RST}, {24'h0, tx_data});
    irq(1'b0);
    $display("test second reset done");
    print_verdict();
  end
endmodule
